// File: src/lfc_fifo.sv
module lfc_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
    logic                        full;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } lfc_fifo_state_t;

  lfc_fifo_state_t st_reg;
  lfc_fifo_state_t st_next;

  logic push;
  logic pop;

  always_comb begin
    st_next = st_reg;
    push    = in_valid_i && !st_reg.full;
    pop     = (st_reg.count != '0) && (!st_reg.out_valid || out_ready_i);
    if (out_ready_i) begin
      st_next.out_valid = 1'b0;
    end
    // Read data always leave through the output register
    if (pop) begin
      st_next.out_valid = 1'b1;
      st_next.out_data  = st_reg.mem[st_reg.rd_ptr];
      st_next.rd_ptr    = st_reg.rd_ptr + 1'b1;
    end
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data_i;
      st_next.wr_ptr             = st_reg.wr_ptr + 1'b1;
    end
    st_next.count = st_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    st_next.full  = (st_next.count == (AW+1)'(DEPTH));
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  assign in_ready_o  = !st_reg.full;
  assign out_valid_o = st_reg.out_valid;
  assign out_data_o  = st_reg.out_data;
endmodule

// File: src/lfc_framer.sv
module lfc_framer (
  // Clock and reset
  input  wire logic                           clock_i,
  input  wire logic                           rst_n_i,
  input  wire logic                           clk_en_i,
  // Timing reference pin
  input  wire logic                           sysref_i,
  // Configuration
  input  wire logic [1:0]                     header_stream_select_i,
  input  wire logic [lfc_pkg::EMB_W-1:0]      emb_count_i,
  // Scrambled payload in
  input  wire logic                           data_valid_i,
  input  wire logic [lfc_pkg::PAY_W-1:0]      data_i,
  output logic                                data_ready_o,
  // Block stream out
  input  wire logic                           tx_ready_i,
  output logic                                block_valid_o,
  output logic [lfc_pkg::BLK_W-1:0]           block_o,
  // Framing markers
  output logic                                multiblock_end_pilot_o,
  output logic                                ext_multiblock_end_flag_o,
  output logic                                ext_multiblock_timing_clock_o,
  output logic                                idle_fill_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]                    sref_sync;
    logic [lfc_pkg::IDX_W-1:0]     blk_idx;
    logic [lfc_pkg::EMB_W-1:0]     mb_idx;
    logic [lfc_pkg::CRC_W-1:0]     crc;
    logic [lfc_pkg::CRC_W-1:0]     crc_par;
    logic [lfc_pkg::FEC_W-1:0]     fec;
    logic [lfc_pkg::FEC_W-1:0]     fec_par;
    logic [lfc_pkg::BLK_W-1:0]     blk;
    logic [lfc_pkg::IDX_W-1:0]     out_idx;
    logic                          out_fec;
    logic                          blk_valid;
    logic                          pilot;
    logic                          ext_multiblock_end_flag;
    logic                          ext_multiblock_timing_clock;
    logic                          fill;
  } lfc_state_t;

  lfc_state_t                  st_reg;
  lfc_state_t                  st_next;

  logic                        fifo_valid;
  logic [lfc_pkg::PAY_W-1:0]   fifo_data;
  logic                        fifo_ready;
  logic                        sref_edge;
  logic                        fec_sel;
  logic [lfc_pkg::EMB_W-1:0]   e_last;
  logic                        last_mb;
  logic [lfc_pkg::PAY_W-1:0]   payload;
  logic [lfc_pkg::CRC_W-1:0]   crc_new;
  logic [lfc_pkg::FEC_W-1:0]   fec_new;
  logic [31:0]                 stream;
  logic                        hdr;

  // ----------------------------------------
  // Parity generators, one 64-bit payload word per step
  // ----------------------------------------
  // Bit 0 of the payload is the first on the line
  function automatic logic [lfc_pkg::CRC_W-1:0] crc_step(input logic [lfc_pkg::CRC_W-1:0] s_in,
                                                         input logic [lfc_pkg::PAY_W-1:0] d);
    logic [lfc_pkg::CRC_W-1:0] s;
    logic                      fb;
    s = s_in;
    for (int i = 0; i < lfc_pkg::PAY_W; i++) begin
      fb = s[lfc_pkg::CRC_W-1] ^ d[i];
      s  = {s[lfc_pkg::CRC_W-2:0], 1'b0} ^ (fb ? lfc_pkg::CRC_POLY : '0);
    end
    return s;
  endfunction

  function automatic logic [lfc_pkg::FEC_W-1:0] fec_step(input logic [lfc_pkg::FEC_W-1:0] s_in,
                                                         input logic [lfc_pkg::PAY_W-1:0] d);
    logic [lfc_pkg::FEC_W-1:0] s;
    logic                      fb;
    s = s_in;
    for (int i = 0; i < lfc_pkg::PAY_W; i++) begin
      fb = s[lfc_pkg::FEC_W-1] ^ d[i];
      s  = {s[lfc_pkg::FEC_W-2:0], 1'b0} ^ (fb ? lfc_pkg::FEC_POLY : '0);
    end
    return s;
  endfunction

  // ----------------------------------------
  // Header stream word for one multiblock
  // ----------------------------------------
  function automatic logic [31:0] build_stream(input logic                      fec,
                                               input logic [lfc_pkg::CRC_W-1:0] cp,
                                               input logic [lfc_pkg::FEC_W-1:0] fp,
                                               input logic                      ext_multiblock_end_flag);
    logic [31:0] s;
    s = '0;
    if (fec) begin
      s = lfc_pkg::FEC_ONES;
      for (int k = 0; k < lfc_pkg::FEC_HI_N; k++) begin
        s[k] = fp[lfc_pkg::FEC_W-1-k];
      end
      s[lfc_pkg::FEC_MID] = fp[lfc_pkg::GRP_BITS];
      for (int t = 0; t < lfc_pkg::GRP_BITS; t++) begin
        s[lfc_pkg::FEC_LO+t] = fp[lfc_pkg::GRP_BITS-1-t];
      end
    end else begin
      s = lfc_pkg::CRC_ONES;
      for (int j = 0; j < lfc_pkg::GRP_N; j++) begin
        for (int t = 0; t < lfc_pkg::GRP_BITS; t++) begin
          s[lfc_pkg::GRP_STEP*j+t] = cp[lfc_pkg::CRC_W-1-lfc_pkg::GRP_BITS*j-t];
        end
      end
    end
    s[lfc_pkg::EXT_MULTIBLOCK_END_FLAG_POS] = ext_multiblock_end_flag;
    return s;
  endfunction

  // ----------------------------------------
  // Payload buffer
  // ----------------------------------------
  // Drained once per advancing block; stalls reach the source
  lfc_fifo #(
    .WIDTH (lfc_pkg::PAY_W),
    .DEPTH (lfc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (data_valid_i),
    .in_data_i   (data_i),
    .in_ready_o  (data_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_ready)
  );

  // ----------------------------------------
  // Framing logic
  // ----------------------------------------
  assign sref_edge  = st_reg.sref_sync[1] && !st_reg.sref_sync[2];
  assign fifo_ready = tx_ready_i && !sref_edge;
  // Codes other than FEC fall back to CRC-12, the only other supported stream
  assign fec_sel    = (header_stream_select_i == lfc_pkg::MODE_FEC);
  assign e_last     = (emb_count_i == '0) ? '0 : emb_count_i - 1'b1;
  assign last_mb    = (st_reg.mb_idx >= e_last);

  always_comb begin
    st_next              = st_reg;
    st_next.sref_sync    = {st_reg.sref_sync[1:0], sysref_i};
    st_next.blk_valid    = 1'b0;
    st_next.pilot        = 1'b0;
    st_next.ext_multiblock_timing_clock         = 1'b0;
    st_next.fill         = 1'b0;
    // Idle blocks keep the multiblock cadence when no payload waits
    payload              = fifo_valid ? fifo_data : '0;
    crc_new              = crc_step((st_reg.blk_idx == '0) ? '0 : st_reg.crc, payload);
    fec_new              = fec_step((st_reg.blk_idx == '0) ? '0 : st_reg.fec, payload);
    stream               = build_stream(fec_sel, st_reg.crc_par, st_reg.fec_par, last_mb);
    hdr                  = stream[st_reg.blk_idx];
    if (sref_edge) begin
      // Phase of the extended multiblock timing restarts here
      st_next.blk_idx    = '0;
      st_next.mb_idx     = '0;
      st_next.crc        = '0;
      st_next.fec        = '0;
      st_next.crc_par    = '0;
      st_next.fec_par    = '0;
    end else if (tx_ready_i) begin
      st_next.blk        = {payload, hdr, ~hdr};
      st_next.blk_valid  = 1'b1;
      st_next.fill       = !fifo_valid;
      st_next.out_idx    = st_reg.blk_idx;
      st_next.out_fec    = fec_sel;
      st_next.ext_multiblock_end_flag      = last_mb;
      st_next.pilot      = (st_reg.blk_idx == lfc_pkg::BLK_LAST);
      st_next.ext_multiblock_timing_clock       = (st_reg.blk_idx == '0) && (st_reg.mb_idx == '0);
      st_next.crc        = crc_new;
      st_next.fec        = fec_new;
      if (st_reg.blk_idx == lfc_pkg::BLK_LAST) begin
        st_next.crc_par  = crc_new;
        st_next.fec_par  = fec_new;
        st_next.blk_idx  = '0;
        st_next.mb_idx   = last_mb ? '0 : st_reg.mb_idx + 1'b1;
      end else begin
        st_next.blk_idx  = st_reg.blk_idx + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  assign block_valid_o                 = st_reg.blk_valid;
  assign block_o                       = st_reg.blk;
  assign multiblock_end_pilot_o        = st_reg.pilot;
  assign ext_multiblock_end_flag_o     = st_reg.ext_multiblock_end_flag;
  assign ext_multiblock_timing_clock_o = st_reg.ext_multiblock_timing_clock;
  assign idle_fill_o                   = st_reg.fill;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_mb_close;
    clk_en_i && tx_ready_i && !sref_edge && st_reg.blk_idx == lfc_pkg::BLK_LAST;
  endsequence

  sequence s_sref_seen;
    clk_en_i && sref_edge;
  endsequence

  property p_hdr_compl;
    @(posedge clock_i) disable iff (!rst_n_i)
      block_valid_o |-> (block_o[0] != block_o[1]);
  endproperty
  a_hdr_compl: assert property (p_hdr_compl) else $error("header bits not complementary");

  property p_payload;
    @(posedge clock_i) disable iff (!rst_n_i)
      (clk_en_i && fifo_valid && fifo_ready) |=> (block_valid_o && block_o[lfc_pkg::BLK_W-1:2] == $past(fifo_data));
  endproperty
  a_payload: assert property (p_payload) else $error("payload not placed above header");

  property p_mb_wrap;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_mb_close |=> (multiblock_end_pilot_o && st_reg.blk_idx == '0);
  endproperty
  a_mb_wrap: assert property (p_mb_wrap) else $error("multiblock not closed after 32 blocks");

  property p_sref;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_sref_seen |=> (st_reg.blk_idx == '0 && st_reg.mb_idx == '0 && !block_valid_o);
  endproperty
  a_sref: assert property (p_sref) else $error("reference edge did not reset timing");

  property p_end_zeros;
    @(posedge clock_i) disable iff (!rst_n_i)
      (block_valid_o && lfc_pkg::END_ZEROS[st_reg.out_idx]) |-> !block_o[1];
  endproperty
  a_end_zeros: assert property (p_end_zeros) else $error("end pattern zero missing");

  property p_end_one;
    @(posedge clock_i) disable iff (!rst_n_i)
      (block_valid_o && st_reg.out_idx == lfc_pkg::BLK_LAST) |-> (block_o[1] && multiblock_end_pilot_o);
  endproperty
  a_end_one: assert property (p_end_one) else $error("end pattern final one missing");

  property p_ext_multiblock_end_flag;
    @(posedge clock_i) disable iff (!rst_n_i)
      (block_valid_o && st_reg.out_idx == lfc_pkg::IDX_W'(lfc_pkg::EXT_MULTIBLOCK_END_FLAG_POS))
        |-> (block_o[1] == ext_multiblock_end_flag_o);
  endproperty
  a_ext_multiblock_end_flag: assert property (p_ext_multiblock_end_flag) else $error("extended end flag wrong");

  property p_ones;
    @(posedge clock_i) disable iff (!rst_n_i)
      (block_valid_o && !st_reg.out_fec && lfc_pkg::CRC_ONES[st_reg.out_idx]) |-> block_o[1];
  endproperty
  a_ones: assert property (p_ones) else $error("fixed one missing");

  property p_cmd;
    @(posedge clock_i) disable iff (!rst_n_i)
      (block_valid_o && !st_reg.out_fec && lfc_pkg::CMD_MASK[st_reg.out_idx]) |-> !block_o[1];
  endproperty
  a_cmd: assert property (p_cmd) else $error("command bit not zero");

  property p_crc_map;
    @(posedge clock_i) disable iff (!rst_n_i)
      (block_valid_o && !st_reg.out_fec && st_reg.out_idx == '0) |-> (block_o[1] == st_reg.crc_par[lfc_pkg::CRC_W-1]);
  endproperty
  a_crc_map: assert property (p_crc_map) else $error("parity msb not in first block");

  property p_fec_map;
    @(posedge clock_i) disable iff (!rst_n_i)
      (block_valid_o && st_reg.out_fec && st_reg.out_idx == '0) |-> (block_o[1] == st_reg.fec_par[lfc_pkg::FEC_W-1]);
  endproperty
  a_fec_map: assert property (p_fec_map) else $error("fec msb not in first block");

  sequence s_restart;
    s_sref_seen ##1 (clk_en_i && tx_ready_i && !sref_edge);
  endsequence

  property p_fill;
    @(posedge clock_i) disable iff (!rst_n_i)
      (clk_en_i && tx_ready_i && !sref_edge && !fifo_valid) |=> (idle_fill_o && block_o[lfc_pkg::BLK_W-1:2] == '0);
  endproperty
  a_fill: assert property (p_fill) else $error("idle block not zero filled");

  property p_ext_multiblock_timing_clock_pos;
    @(posedge clock_i) disable iff (!rst_n_i)
      ext_multiblock_timing_clock_o |-> (block_valid_o && st_reg.out_idx == '0);
  endproperty
  a_ext_multiblock_timing_clock_pos: assert property (p_ext_multiblock_timing_clock_pos) else $error("timing pulse off block zero");

  property p_pilot_pos;
    @(posedge clock_i) disable iff (!rst_n_i)
      multiblock_end_pilot_o |-> (block_valid_o && st_reg.out_idx == lfc_pkg::BLK_LAST);
  endproperty
  a_pilot_pos: assert property (p_pilot_pos) else $error("end pilot off last block");

  property p_par_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      (clk_en_i && !sref_edge && !(tx_ready_i && st_reg.blk_idx == lfc_pkg::BLK_LAST))
        |=> (st_reg.crc_par == $past(st_reg.crc_par));
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("parity changed inside multiblock");

  property p_par_clear;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_sref_seen |=> (st_reg.crc == '0 && st_reg.crc_par == '0);
  endproperty
  a_par_clear: assert property (p_par_clear) else $error("parity state not cleared");

  property p_mb_step;
    @(posedge clock_i) disable iff (!rst_n_i)
      (s_mb_close ##0 last_mb) |=> (st_reg.mb_idx == '0);
  endproperty
  a_mb_step: assert property (p_mb_step) else $error("extended multiblock did not wrap");

  property p_crc_lsb;
    @(posedge clock_i) disable iff (!rst_n_i)
      (block_valid_o && !st_reg.out_fec &&
       st_reg.out_idx == lfc_pkg::IDX_W'(lfc_pkg::GRP_STEP*(lfc_pkg::GRP_N-1)+lfc_pkg::GRP_BITS-1))
        |-> (block_o[1] == st_reg.crc_par[0]);
  endproperty
  a_crc_lsb: assert property (p_crc_lsb) else $error("parity lsb misplaced");

  property p_fec_mid;
    @(posedge clock_i) disable iff (!rst_n_i)
      (block_valid_o && st_reg.out_fec && st_reg.out_idx == lfc_pkg::IDX_W'(lfc_pkg::FEC_MID))
        |-> (block_o[1] == st_reg.fec_par[lfc_pkg::GRP_BITS]);
  endproperty
  a_fec_mid: assert property (p_fec_mid) else $error("fec bit three misplaced");

  property p_restart;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_restart |=> (ext_multiblock_timing_clock_o && block_valid_o);
  endproperty
  a_restart: assert property (p_restart) else $error("no timing pulse after reference");
endmodule

// File: src/lfc_pkg.sv
package lfc_pkg;
  // ----------------------------------------
  // Block layout
  // ----------------------------------------
  localparam int          PAY_W      = 64;
  localparam int          BLK_W      = 66;
  localparam int          FIFO_DEPTH = 8;
  localparam int          IDX_W      = 5;
  localparam int          EMB_W      = 8;
  localparam logic [4:0]  BLK_LAST   = 5'h1F;
  // ----------------------------------------
  // Header stream layout
  // ----------------------------------------
  localparam int          CRC_W      = 12;
  localparam int          FEC_W      = 26;
  localparam int          GRP_N      = 4;
  localparam int          GRP_BITS   = 3;
  localparam int          GRP_STEP   = 4;
  localparam int          FEC_HI_N   = 22;
  localparam int          EXT_MULTIBLOCK_END_FLAG_POS  = 22;
  localparam int          FEC_MID    = 23;
  localparam int          FEC_LO     = 24;
  localparam int          CMD_N      = 7;
  localparam logic [31:0] CRC_ONES   = 32'h80A88888;
  localparam logic [31:0] CMD_MASK   = 32'h07170000;
  localparam logic [31:0] END_ZEROS  = 32'h78000000;
  localparam logic [31:0] FEC_ONES   = 32'h80000000;
  // Taps below the top term; the top term is implied
  localparam logic [11:0] CRC_POLY   = 12'h30F;
  localparam logic [25:0] FEC_POLY   = 26'h0220211;
  // ----------------------------------------
  // Header stream select codes
  // ----------------------------------------
  localparam logic [1:0]  MODE_CRC12 = 2'h0;
  localparam logic [1:0]  MODE_FEC   = 2'h2;
endpackage

// File: testbench/lfc_framer_test.sv
module lfc_framer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i      = 1'b0;
  logic        rst_n_i      = 1'b0;
  logic        clk_en_i     = 1'b1;
  logic        sysref_i     = 1'b0;
  logic [1:0]  sel          = 2'h0;
  logic [7:0]  emb          = 8'h01;
  logic [1:0]  tx_stall     = 2'h0;
  logic        data_valid_i = 1'b0;
  logic [63:0] data_i       = 64'h0;
  logic        data_ready_o;
  logic        tx_ready;
  logic        block_valid_o;
  logic [65:0] block_o;
  logic        pilot;
  logic        ext_multiblock_end_flag;
  logic        ext_multiblock_timing_clock;
  logic        idle;
  int          miscompares  = 0;
  int          cmp_count    = 0;
  int          cycles       = 0;

  always #4 clock_i = ~clock_i;

  lfc_framer i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .sysref_i(sysref_i),
    .header_stream_select_i(sel), .emb_count_i(emb), .data_valid_i(data_valid_i), .data_i(data_i),
    .data_ready_o(data_ready_o), .tx_ready_i(tx_ready), .block_valid_o(block_valid_o), .block_o(block_o),
    .multiblock_end_pilot_o(pilot), .ext_multiblock_end_flag_o(ext_multiblock_end_flag),
    .ext_multiblock_timing_clock_o(ext_multiblock_timing_clock), .idle_fill_o(idle));

  lfc_rx_model i_rx (.clock_i(clock_i), .rst_n_i(rst_n_i), .en_i(clk_en_i), .sysref_i(sysref_i),
    .mode_i(sel), .emb_i(emb), .stall_i(tx_stall), .valid_i(block_valid_o), .block_i(block_o),
    .pilot_i(pilot), .ext_multiblock_end_flag_i(ext_multiblock_end_flag), .ext_multiblock_timing_clock_i(ext_multiblock_timing_clock), .idle_i(idle), .ready_o(tx_ready));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp_word(input logic [65:0] got, input logic [65:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_int(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [63:0] word(input logic [31:0] base, input int i);
    return {base + 32'(i), 32'h9E3779B9 ^ 32'(i * 7)};
  endfunction

  // Holds the word until an enabled edge sees the FIFO ready
  task automatic send(input logic [63:0] w);
    int n;
    data_valid_i <= 1'b1;
    data_i       <= w;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (!(data_ready_o === 1'b1 && clk_en_i === 1'b1) && n < 300);
    if (n >= 300) miscompares++;
  endtask

  task automatic check_words(input int n, input logic [31:0] base);
    int k;
    k = 0;
    while (i_rx.got.size() < n && k < 2000) begin
      @(posedge clock_i);
      k++;
    end
    cmp_int(i_rx.got.size(), n);
    for (int i = 0; i < i_rx.got.size(); i++) cmp_word({2'b00, i_rx.got[i]}, {2'b00, word(base, i)});
  endtask

  // One-shot reference pulse, trivially within the allowed rates
  task automatic pulse_sysref();
    int k;
    sysref_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    sysref_i <= 1'b0;
    k = 0;
    while (!(ext_multiblock_timing_clock === 1'b1 && block_valid_o === 1'b1) && k < 16) begin
      @(posedge clock_i);
      k++;
    end
    cmp_int(int'(k < 16), 1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_stream();
    tx_stall <= 2'h1;
    i_rx.got.delete();
    for (int i = 0; i < 24; i++) send(word(32'hA0000000, i));
    data_valid_i <= 1'b0;
    check_words(24, 32'hA0000000);
    $display("stream test done");
  endtask

  task automatic t_fill();
    int k;
    tx_stall <= 2'h2;
    repeat (3) @(posedge clock_i);
    i_rx.got.delete();
    k = 0;
    data_valid_i <= 1'b1;
    for (int j = 0; j < 16; j++) begin
      data_i <= word(32'h5B000000, k);
      @(posedge clock_i);
      if (data_ready_o === 1'b1) k++;
    end
    data_valid_i <= 1'b0;
    cmp_int(k, lfc_pkg::FIFO_DEPTH + 1);
    cmp_word({65'h0, data_ready_o}, 66'h0);
    tx_stall <= 2'h1;
    repeat (40) @(posedge clock_i) clk_en_i <= ~clk_en_i;
    clk_en_i <= 1'b1;
    check_words(k, 32'h5B000000);
    repeat (4) @(posedge clock_i);
    cmp_word({65'h0, data_ready_o}, 66'h1);
    $display("fill test done");
  endtask

  task automatic t_modes();
    logic [1:0] modes[4];
    logic [7:0] counts[4];
    int         m0;
    int         k;
    modes  = '{2'h0, 2'h1, 2'h2, 2'h3};
    counts = '{8'h01, 8'h03, 8'h00, 8'h02};
    tx_stall <= 2'h0;
    for (int t = 0; t < 4; t++) begin
      sel <= modes[t];
      emb <= counts[t];
      pulse_sysref();
      m0 = i_rx.mb_ok;
      for (int i = 0; i < 40; i++) send(word(32'h3C000000 + 32'(t), i));
      data_valid_i <= 1'b0;
      k = 0;
      while (i_rx.mb_ok < m0 + 4 && k < 3000) begin
        @(posedge clock_i);
        k++;
      end
      cmp_int(int'(i_rx.mb_ok >= m0 + 4), 1);
    end
    cmp_int(i_rx.hdr_err, 0);
    cmp_int(i_rx.frame_err, 0);
    cmp_int(i_rx.crc_err, 0);
    $display("mode test done");
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("time limit reached");
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge clock_i);
    cmp_word({65'h0, data_ready_o}, 66'h1);
    cmp_word({65'h0, block_valid_o}, 66'h0);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    $display("reset test done");
    t_stream();
    t_fill();
    t_modes();
    conclude();
  end
endmodule

// File: testbench/lfc_rx_model.sv
module lfc_rx_model (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  // Settings shared by both link ends; stall_i is the model's own
  input  wire logic        sysref_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [7:0]  emb_i,
  input  wire logic [1:0]  stall_i,
  // Block stream from the framer
  input  wire logic        valid_i,
  input  wire logic [65:0] block_i,
  input  wire logic        pilot_i,
  input  wire logic        ext_multiblock_end_flag_i,
  input  wire logic        ext_multiblock_timing_clock_i,
  input  wire logic        idle_i,
  output logic             ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned hdr_err   = 0;
  int unsigned frame_err = 0;
  int unsigned crc_err   = 0;
  int unsigned mb_ok     = 0;
  int unsigned cyc       = 0;
  logic [63:0] got[$];
  logic        aligned   = 1'b0;
  int unsigned sref_hold = 0;
  logic [25:0] flsr      = 26'h0;
  logic [25:0] fprev     = 26'h0;
  logic [4:0]  blk       = 5'h1F;
  logic [7:0]  mb        = 8'h00;
  logic [11:0] lfsr      = 12'h000;
  logic [11:0] prev      = 12'h000;
  logic [31:0] shs       = 32'h0;

  initial ready_o = 1'b0;

  // ----------------------------------------
  // Expected header stream in parity mode
  // ----------------------------------------
  function automatic logic [31:0] crc_stream(input logic [11:0] c, input logic e);
    logic [31:0] s;
    s = 32'h0;
    for (int g = 0; g < 4; g++) begin
      for (int b = 0; b < 3; b++) begin
        s[4*g+b] = c[11-3*g-b];
      end
      s[4*g+3] = 1'b1;
    end
    s[19] = 1'b1;
    s[21] = 1'b1;
    s[23] = 1'b1;
    s[31] = 1'b1;
    s[22] = e;
    return s;
  endfunction

  // ----------------------------------------
  // Receive one block
  // ----------------------------------------
  task automatic take();
    logic [4:0]  nb;
    logic [7:0]  nm;
    logic [7:0]  e;
    logic        fb;
    logic        ff;
    logic [31:0] ef;
    e  = (emb_i == 8'h00) ? 8'h01 : emb_i;
    nb = blk + 5'h01;
    nm = (blk != 5'h1F) ? mb : ((mb + 8'h01 >= e) ? 8'h00 : mb + 8'h01);
    if (block_i[0] === block_i[1]) hdr_err++;
    if (idle_i === 1'b1 && block_i[65:2] !== 64'h0) frame_err++;
    if (idle_i === 1'b0) got.push_back(block_i[65:2]);
    if (aligned && ext_multiblock_timing_clock_i !== (nb == 5'h00 && nm == 8'h00)) frame_err++;
    if (ext_multiblock_timing_clock_i === 1'b1) begin
      nb      = 5'h00;
      nm      = 8'h00;
      aligned = 1'b1;
    end
    blk = nb;
    mb  = nm;
    if (!aligned) return;
    if (nb == 5'h00) lfsr = 12'h000;
    if (nb == 5'h00) flsr = 26'h0;
    if (pilot_i !== (nb == 5'h1F) || ext_multiblock_end_flag_i !== (nm == e - 8'h01)) frame_err++;
    shs[nb] = block_i[1];
    for (int i = 0; i < 64; i++) begin
      fb   = lfsr[11] ^ block_i[2+i];
      lfsr = {lfsr[10:0], 1'b0} ^ (fb ? 12'h30F : 12'h000);
      ff   = flsr[25] ^ block_i[2+i];
      flsr = {flsr[24:0], 1'b0} ^ (ff ? 26'h0220211 : 26'h0);
    end
    if (nb == 5'h1F) begin
      if (mode_i == 2'h2) begin
        ef = 32'h80000000;
        for (int k = 0; k < 22; k++) ef[k] = fprev[25-k];
        ef[23]    = fprev[3];
        ef[26:24] = {fprev[0], fprev[1], fprev[2]};
        ef[22]    = (nm == e - 8'h01);
        if (shs !== ef) frame_err++;
      end else begin
        if (shs !== crc_stream(prev, nm == e - 8'h01)) crc_err++;
        for (int p = 0; p < 27; p++) if (shs[p+:5] === 5'b10000) frame_err++;
      end
      prev  = lfsr;
      fprev = flsr;
      mb_ok++;
    end
  endtask

  // Stall 1 accepts a block every other cycle, stall 2 refuses all
  always @(posedge clock_i) begin
    cyc++;
    ready_o <= (stall_i == 2'h0) ? 1'b1 : ((stall_i == 2'h1) ? cyc[0] : 1'b0);
    if (rst_n_i !== 1'b1) begin
      aligned   = 1'b0;
      prev      = 12'h000;
      fprev     = 26'h0;
      blk       = 5'h1F;
      mb        = 8'h00;
    end else begin
      // Blocks in flight until the synced reference edge lands are skipped
      if (sysref_i === 1'b1) sref_hold = 4;
      if (sref_hold != 0) begin
        sref_hold--;
        aligned = 1'b0;
        prev    = 12'h000;
        fprev   = 26'h0;
      end
      if (sref_hold == 0 && en_i === 1'b1 && valid_i === 1'b1) take();
    end
  end
endmodule
